// ==== hdl/sweep_pkg.sv ====
// sweep_pkg: shared widths, timing constants and encodings for the sweep sequencer.
// assumes a single 25 MHz system clock domain.
package sweep_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_NS = 40;
  localparam int SETTLE_NS_DEF = 200;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int FREQ_W = 32;
  localparam int PWR_W = 16;
  localparam int DWELL_W = 24;
  localparam int IDX_W = 8;
  localparam int LOG_FRAC = 16;
  localparam int PEND_W = 3;
  localparam int SETTLE_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // encodings
  typedef enum logic [1:0] {
    FM_CW    = 2'h0,
    FM_STEP  = 2'h1,
    FM_LIST  = 2'h2,
    FM_SLOPE = 2'h3
  } fmode_t;

  typedef enum logic [1:0] {
    TRG_AUTO = 2'h0,
    TRG_EXT  = 2'h1,
    TRG_MAN  = 2'h2
  } trig_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_WAIT = 3'h1,
    S_RUN  = 3'h2,
    S_LOAD = 3'h3,
    S_DONE = 3'h4
  } seq_state_t;

endpackage

// ==== hdl/list_table.sv ====
// list_table: entry memory for list sweep, one write port, registered read.
// assumes writes and reads share clk_sys; read data lags the address by one edge.
`timescale 1ns/1ps
module list_table
  import sweep_pkg::*;
#(
  parameter int AW = IDX_W,
  parameter int W = FREQ_W + PWR_W + DWELL_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // read side
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);

  logic [W-1:0] mem [2**AW];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // contents are undefined until software loads them
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // list_table

// ==== hdl/rf_sweep_sequencer.sv ====
// rf_sweep_sequencer: steps the synthesizer setpoint through step or list sweeps.
// assumes config inputs are on clk_sys; ext_trig is an asynchronous pin.
`timescale 1ns/1ps
module rf_sweep_sequencer
  import sweep_pkg::*;
#(
  parameter int SETTLE_NS = SETTLE_NS_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // mode and sequencing
  input wire fmode_t freq_mode,
  input wire logic sweep_on,
  input wire trig_t start_trig,
  input wire trig_t point_trig,
  input wire logic run_single,
  input wire logic retrace,
  input wire logic shape_tri,
  input wire logic spacing_log,
  // range and step
  input wire logic range_center,
  input wire logic [FREQ_W-1:0] start_freq,
  input wire logic [FREQ_W-1:0] stop_freq,
  input wire logic [FREQ_W-1:0] center_freq,
  input wire logic [FREQ_W-1:0] span_freq,
  input wire logic [FREQ_W-1:0] step_lin,
  input wire logic [LOG_FRAC-1:0] step_log,
  input wire logic [DWELL_W-1:0] step_dwell,
  // fixed output
  input wire logic [FREQ_W-1:0] cw_freq,
  input wire logic [PWR_W-1:0] cw_power,
  // list sweep
  input wire logic list_dwell_global,
  input wire logic [DWELL_W-1:0] global_dwell,
  input wire logic [IDX_W-1:0] list_start,
  input wire logic [IDX_W-1:0] list_stop,
  input wire logic tbl_we,
  input wire logic [IDX_W-1:0] tbl_addr,
  input wire logic [FREQ_W-1:0] tbl_freq,
  input wire logic [PWR_W-1:0] tbl_power,
  input wire logic [DWELL_W-1:0] tbl_dwell,
  // commands, one-cycle pulses
  input wire logic start_cmd,
  input wire logic point_cmd,
  input wire logic restart_cmd,
  // trigger pin
  input wire logic ext_trig,
  // synthesizer setpoint
  output logic [FREQ_W-1:0] set_freq,
  output logic [PWR_W-1:0] set_power,
  output logic set_valid,
  // status
  output logic sweep_active,
  output logic sweep_done,
  output logic cw_out_active,
  output logic list_active,
  output logic point_delayed,
  output logic [IDX_W-1:0] list_index
);

  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [SETTLE_W-1:0] SETTLE_LD = SETTLE_W'(SETTLE_CYC - 1);
  localparam logic [PEND_W-1:0] PEND_MAX = '1;
  localparam int TW = FREQ_W + PWR_W + DWELL_W;

  // back-to-back valid pulses would break the one-cycle strobe
  if (SETTLE_CYC < 2 || SETTLE_CYC > 2**SETTLE_W) begin : g_chk
    $error("SETTLE_NS out of range for this clock");
  end

  typedef struct packed {
    seq_state_t st;
    fmode_t mode;
    logic [FREQ_W-1:0] freq;
    logic [PWR_W-1:0] pwr;
    logic valid;
    logic [DWELL_W-1:0] cnt;
    logic [SETTLE_W-1:0] settle;
    logic [IDX_W-1:0] idx;
    logic down;
    logic fin;
    logic cw_sent;
    logic [PEND_W-1:0] pend;
    logic [1:0] sync;
    logic ext_prev;
  } sq_t;

  sq_t st_q;
  sq_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_list(fmode_t m);
    return m == FM_LIST;
  endfunction

  function automatic logic trig_hit(trig_t t, logic man, logic ext);
    return (t == TRG_MAN) ? man : (t == TRG_EXT) ? ext : 1'b0;
  endfunction

  // setpoint issue: dwell and settle counters restart together
  function automatic sq_t emit(sq_t s, logic [FREQ_W-1:0] f, logic [PWR_W-1:0] p,
                               logic [DWELL_W-1:0] d);
    s.freq = f;
    s.pwr = p;
    s.valid = 1'b1;
    s.cnt = (d == '0) ? '0 : d - 1'b1;
    s.settle = SETTLE_LD;
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // range and next step

  logic [FREQ_W-1:0] lo;
  logic [FREQ_W-1:0] hi;
  logic [FREQ_W+LOG_FRAC-1:0] prod;
  logic [FREQ_W-1:0] inc;
  logic [FREQ_W:0] sum;
  logic top;
  logic bot;
  logic [FREQ_W-1:0] nxt_up;
  logic [FREQ_W-1:0] nxt_dn;

  always_comb begin
    lo = range_center ? center_freq - (span_freq >> 1) : start_freq;
    hi = range_center ? center_freq + (span_freq >> 1) : stop_freq;
    prod = {{LOG_FRAC{1'b0}}, st_q.freq} * {{FREQ_W{1'b0}}, step_log};
    inc = spacing_log ? prod[FREQ_W+LOG_FRAC-1:LOG_FRAC] : step_lin;
    if (inc == '0) begin
      inc = {{(FREQ_W-1){1'b0}}, 1'b1};
    end
    sum = {1'b0, st_q.freq} + {1'b0, inc};
    top = sum >= {1'b0, hi};
    nxt_up = top ? hi : sum[FREQ_W-1:0];
    bot = (st_q.freq <= lo) || (st_q.freq - lo <= inc);
    nxt_dn = bot ? lo : st_q.freq - inc;
  end

  ////////////////////////////////////////////////////////////////////////////
  // list memory

  logic [TW-1:0] rd_word;
  logic [FREQ_W-1:0] rd_freq;
  logic [PWR_W-1:0] rd_power;
  logic [DWELL_W-1:0] rd_dwell;

  // address from the next index so data is ready in the load state
  list_table #(.AW(IDX_W), .W(TW)) u_table (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .wr_en(tbl_we),
    .wr_addr(tbl_addr),
    .wr_data({tbl_freq, tbl_power, tbl_dwell}),
    .rd_addr(st_d.idx),
    .rd_data(rd_word)
  );

  assign {rd_freq, rd_power, rd_dwell} = rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  logic ext_edge;
  logic ready;
  logic pt_evt;
  logic adv;
  logic go;
  logic fin_sweep;
  logic abort;
  logic [PEND_W-1:0] pend_nx;

  assign ext_edge = st_q.sync[1] & ~st_q.ext_prev;
  assign ready = st_q.settle == '0;
  assign pt_evt = (st_q.st == S_RUN || st_q.st == S_LOAD)
                  && trig_hit(point_trig, point_cmd, ext_edge);
  assign adv = (st_q.st == S_RUN) && ready
               && ((point_trig == TRG_AUTO) ? st_q.cnt == '0 : st_q.pend != '0);
  assign abort = (st_q.st != S_IDLE) && (!sweep_on || freq_mode != st_q.mode);

  always_comb begin
    pend_nx = st_q.pend;
    if (pt_evt && st_q.pend != PEND_MAX) begin
      pend_nx = pend_nx + 1'b1;
    end
    if (adv && point_trig != TRG_AUTO) begin
      pend_nx = pend_nx - 1'b1;
    end
  end

  always_comb begin
    st_d = st_q;
    go = 1'b0;
    fin_sweep = 1'b0;
    st_d.valid = 1'b0;
    st_d.mode = freq_mode;
    st_d.sync = {st_q.sync[0], ext_trig};
    st_d.ext_prev = st_q.sync[1];
    st_d.pend = pend_nx;
    if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
    if (st_q.settle != '0) begin
      st_d.settle = st_q.settle - 1'b1;
    end
    unique case (st_q.st)
      S_IDLE: begin
        st_d.pend = '0;
        if (freq_mode == FM_CW) begin
          // fixed frequency only reaches the synthesizer in cw mode; cw_power is also the power of step and slope sweeps
          if (!st_q.cw_sent || cw_freq != st_q.freq || cw_power != st_q.pwr) begin
            st_d = emit(st_d, cw_freq, cw_power, '0);
            st_d.cw_sent = 1'b1;
          end
        end else if (sweep_on) begin
          st_d.cw_sent = 1'b0;
          if (start_trig == TRG_AUTO) begin
            go = 1'b1;
          end else begin
            st_d.st = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        st_d.pend = '0;
        go = trig_hit(start_trig, start_cmd, ext_edge);
      end
      S_RUN: begin
        if (adv) begin
          if (is_list(st_q.mode)) begin
            if (st_q.idx == list_stop) begin
              fin_sweep = 1'b1;
            end else begin
              st_d.idx = st_q.idx + 1'b1;
              st_d.st = S_LOAD;
            end
          end else if (!st_q.down) begin
            if (st_q.freq >= hi) begin
              if (shape_tri) begin
                st_d.down = 1'b1;
                st_d = emit(st_d, nxt_dn, cw_power, step_dwell);
              end else begin
                fin_sweep = 1'b1;
              end
            end else begin
              st_d = emit(st_d, nxt_up, cw_power, step_dwell);
            end
          end else if (st_q.freq <= lo) begin
            fin_sweep = 1'b1;
          end else begin
            st_d = emit(st_d, nxt_dn, cw_power, step_dwell);
          end
        end
      end
      S_LOAD: begin
        st_d = emit(st_d, rd_freq, rd_power, list_dwell_global ? global_dwell : rd_dwell);
        st_d.st = st_q.fin ? S_DONE : S_RUN;
      end
      S_DONE: begin
        st_d.pend = '0;
        go = restart_cmd && run_single;
      end
      default: begin
        st_d.st = S_IDLE;
      end
    endcase
    if (fin_sweep) begin
      if (!run_single) begin
        go = 1'b1;
      end else if (!retrace) begin
        st_d.st = S_DONE;
      end else if (is_list(st_q.mode)) begin
        st_d.idx = list_start;
        st_d.fin = 1'b1;
        st_d.st = S_LOAD;
      end else begin
        st_d = emit(st_d, lo, cw_power, step_dwell);
        st_d.st = S_DONE;
      end
    end
    if (go) begin
      st_d.down = 1'b0;
      st_d.fin = 1'b0;
      st_d.pend = '0;
      if (is_list(freq_mode)) begin
        st_d.idx = list_start;
        st_d.st = S_LOAD;
      end else begin
        st_d = emit(st_d, lo, cw_power, step_dwell);
        st_d.st = S_RUN;
      end
    end
    if (abort) begin
      st_d.st = S_IDLE;
      st_d.cw_sent = 1'b0;
      // a point falling due in the abort cycle must not reach the synthesizer
      st_d.valid = 1'b0;
      st_d.freq = st_q.freq;
      st_d.pwr = st_q.pwr;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{st: S_IDLE, mode: FM_CW, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign set_freq = st_q.freq;
  assign set_power = st_q.pwr;
  assign set_valid = st_q.valid;
  assign sweep_active = st_q.st != S_IDLE;
  assign sweep_done = st_q.st == S_DONE;
  assign cw_out_active = st_q.mode == FM_CW;
  assign list_active = is_list(st_q.mode);
  assign point_delayed = st_q.pend != '0;
  assign list_index = st_q.idx;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  logic stable;
  logic lin_up;
  assign stable = sweep_on && freq_mode == st_q.mode;
  assign lin_up = adv && !is_list(st_q.mode) && !spacing_log && !st_q.down && !top
                  && st_q.freq < hi && stable;

  sequence s_sweep_emit;
    set_valid && sweep_active;
  endsequence

  sequence s_quiet;
    !set_valid;
  endsequence

  property p_cw_excl;
    set_valid && !sweep_active |-> cw_out_active && !list_active;
  endproperty
  a_cw_excl: assert property (p_cw_excl) else $error("fixed setpoint sent outside cw mode");

  property p_valid_pulse;
    s_sweep_emit |=> s_quiet;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("setpoint strobe longer than one cycle");

  property p_ext_once;
    ext_edge |-> $past(ext_trig, 2) && !$past(ext_trig, 3) ##1 !ext_edge;
  endproperty
  a_ext_once: assert property (p_ext_once) else $error("trigger edge counted twice");

  property p_auto_start;
    st_q.st == S_IDLE && stable && freq_mode != FM_CW && start_trig == TRG_AUTO |=> sweep_active;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("auto start did not begin sweep");

  property p_ext_wait;
    st_q.st == S_WAIT && start_trig == TRG_EXT && !ext_edge && stable |=> st_q.st == S_WAIT && !set_valid;
  endproperty
  a_ext_wait: assert property (p_ext_wait) else $error("sweep left wait without trigger");

  property p_settle;
    adv |-> st_q.settle == '0 && !set_valid && !(SETTLE_CYC > 2 && $past(set_valid, 1));
  endproperty
  a_settle: assert property (p_settle) else $error("advance before settling");

  property p_dwell;
    st_q.st == S_RUN && point_trig == TRG_AUTO && st_q.cnt > 1 && stable |=> !set_valid;
  endproperty
  a_dwell: assert property (p_dwell) else $error("point left before dwell expiry");

  property p_step_lin;
    lin_up |=> set_valid && set_freq == $past(st_q.freq) + $past(step_lin);
  endproperty
  a_step_lin: assert property (p_step_lin) else $error("linear step wrong");

  property p_pend;
    pt_evt && !adv && st_q.pend != PEND_MAX && stable |=> st_q.pend == $past(st_q.pend) + 1'b1;
  endproperty
  a_pend: assert property (p_pend) else $error("early trigger lost");

endmodule // rf_sweep_sequencer

// ==== tb/synth_model.sv ====
// synth_model: stands in for the synthesizer and for the rear trigger source.
// assumes set_* are registered on clk_sys; ext_trig changes only at posedge.
`timescale 1ns/1ps
module synth_model
  import sweep_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // setpoint
  input wire logic [FREQ_W-1:0] set_freq,
  input wire logic [PWR_W-1:0] set_power,
  input wire logic set_valid,
  // trigger pin
  output logic ext_trig
);
  logic [FREQ_W-1:0] gf[$];
  logic [PWR_W-1:0] gp[$];
  longint gt[$];
  longint cyc = 0;
  int bad = 0;
  logic vq = 1'b0;

  initial ext_trig = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // setpoint capture; back-to-back strobes are counted as faults
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    vq <= set_valid;
    if (rstn === 1'b1 && set_valid === 1'b1) begin
      gf.push_back(set_freq);
      gp.push_back(set_power);
      gt.push_back(cyc);
      if (vq === 1'b1) bad <= bad + 1;
    end
  end

  task automatic clr();
    gf.delete();
    gp.delete();
    gt.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // wide pulses: a level-sensitive receiver would count them more than once
  task automatic fire(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      ext_trig <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_trig <= 1'b0;
      repeat (12) @(posedge clk_sys);
    end
  endtask
endmodule // synth_model

// ==== tb/tb_top.sv ====
// tb_top: self-checking bench, setpoints compared with a queue model.
// assumes sweep_pkg, list_table and rf_sweep_sequencer are compiled first.
`timescale 1ns/1ps
module tb_top;
  import sweep_pkg::*;
  localparam int SNS = 80;
  localparam int SC = SNS / CLK_NS;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  fmode_t freq_mode = FM_CW;
  trig_t start_trig = TRG_AUTO;
  trig_t point_trig = TRG_AUTO;
  logic sweep_on = 1'b0, run_single = 1'b1, retrace = 1'b0, shape_tri = 1'b0, spacing_log = 1'b0;
  logic range_center = 1'b0, list_dwell_global = 1'b0, tbl_we = 1'b0;
  logic start_cmd = 1'b0, point_cmd = 1'b0, restart_cmd = 1'b0;
  logic [FREQ_W-1:0] start_freq = '0, stop_freq = '0, center_freq = '0, span_freq = '0, step_lin = '0;
  logic [FREQ_W-1:0] cw_freq = 32'h0001_2345, tbl_freq = '0;
  logic [LOG_FRAC-1:0] step_log = '0;
  logic [DWELL_W-1:0] step_dwell = '0, global_dwell = '0, tbl_dwell = '0;
  logic [PWR_W-1:0] cw_power = 16'h0a5a, tbl_power = '0;
  logic [IDX_W-1:0] list_start = '0, list_stop = '0, tbl_addr = '0;
  logic [FREQ_W-1:0] set_freq;
  logic [PWR_W-1:0] set_power;
  logic set_valid, sweep_active, sweep_done, cw_out_active, list_active, point_delayed, ext_trig;
  logic [IDX_W-1:0] list_index;
  int err_count = 0;
  int n_compared = 0;
  logic [31:0] rng = 32'h0968_61f0;
  longint ef[$];
  longint ep[$];
  longint dw[4];

  rf_sweep_sequencer #(.SETTLE_NS(SNS)) u_dut (.clk_sys(clk_sys), .rstn(rstn), .freq_mode(freq_mode),
    .sweep_on(sweep_on), .start_trig(start_trig), .point_trig(point_trig), .run_single(run_single),
    .retrace(retrace), .shape_tri(shape_tri), .spacing_log(spacing_log), .range_center(range_center),
    .start_freq(start_freq), .stop_freq(stop_freq), .center_freq(center_freq), .span_freq(span_freq),
    .step_lin(step_lin), .step_log(step_log), .step_dwell(step_dwell), .cw_freq(cw_freq), .cw_power(cw_power),
    .list_dwell_global(list_dwell_global), .global_dwell(global_dwell), .list_start(list_start),
    .list_stop(list_stop), .tbl_we(tbl_we), .tbl_addr(tbl_addr), .tbl_freq(tbl_freq), .tbl_power(tbl_power),
    .tbl_dwell(tbl_dwell), .start_cmd(start_cmd), .point_cmd(point_cmd), .restart_cmd(restart_cmd),
    .ext_trig(ext_trig), .set_freq(set_freq), .set_power(set_power), .set_valid(set_valid),
    .sweep_active(sweep_active), .sweep_done(sweep_done), .cw_out_active(cw_out_active),
    .list_active(list_active), .point_delayed(point_delayed), .list_index(list_index));
  synth_model u_syn (.clk_sys(clk_sys), .rstn(rstn), .set_freq(set_freq), .set_power(set_power),
    .set_valid(set_valid), .ext_trig(ext_trig));

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  function automatic longint inc(longint f);
    longint i;
    i = spacing_log ? (f * longint'(step_log)) >> 16 : longint'(step_lin);
    return (i < 1) ? 1 : i;
  endfunction
  // model of one step sweep; continuous runs are built by repeating it
  task automatic gen(input longint lo, input longint hi);
    longint f;
    f = lo;
    ef = {lo};
    while (f < hi) begin
      f = f + inc(f);
      if (f > hi) f = hi;
      ef.push_back(f);
    end
    while (shape_tri && f > lo) begin
      f = f - inc(f);
      if (f < lo) f = lo;
      ef.push_back(f);
    end
    if (retrace) ef.push_back(lo);
    ep = {};
    foreach (ef[i]) ep.push_back(cw_power);
  endtask
  task automatic collect();
    int k;
    k = 0;
    while (u_syn.gf.size() < ef.size() && k < 4000) begin
      @(posedge clk_sys);
      k++;
    end
    chk("setpoint count", ef.size(), u_syn.gf.size());
    foreach (ef[i]) if (i < u_syn.gf.size()) begin
      chk("set_freq", ef[i], u_syn.gf[i]);
      chk("set_power", ep[i], u_syn.gp[i]);
    end
  endtask
  task automatic go();
    u_syn.clr();
    @(posedge clk_sys);
    sweep_on <= 1'b1;
    collect();
  endtask
  // end of a single sweep: done flag set and nothing emitted after it
  task automatic fin1();
    int k;
    k = 0;
    while (sweep_done !== 1'b1 && k < 500) begin
      @(posedge clk_sys);
      k++;
    end
    tick(20);
    chk("sweep_done", 1, sweep_done);
    chk("setpoints after end", ef.size(), u_syn.gf.size());
  endtask
  task automatic stop(input string nm);
    @(posedge clk_sys);
    sweep_on <= 1'b0;
    tick(4);
    chk("sweep_active", 0, sweep_active);
    $display("test %s done", nm);
  endtask
  function automatic longint iv(int i);
    return u_syn.gt[i+1] - u_syn.gt[i];
  endfunction
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    $display("BAD watchdog expected end seen hang");
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  initial begin
    logic [31:0] r;
    longint off;
    bit seen;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    ef = {cw_freq};
    ep = {cw_power};
    collect();
    chk("cw_out_active", 1, cw_out_active);
    $display("test reset done");
    @(posedge clk_sys);
    freq_mode <= FM_STEP;
    start_freq <= 32'h0000_1000 + (nxt() & 32'h0000_0fff);
    step_lin <= 32'h0000_0040 + (nxt() & 32'h0000_00ff);
    step_dwell <= DWELL_W'(SC + 1 + (nxt() & 32'h0000_0007));
    @(posedge clk_sys);
    stop_freq <= start_freq + step_lin * 5 + (step_lin >> 1);
    tick(1);
    gen(start_freq, stop_freq);
    go();
    for (int i = 0; i < 6; i++) chk("dwell", step_dwell, iv(i));
    fin1();
    u_syn.clr();
    @(posedge clk_sys);
    restart_cmd <= 1'b1;
    cw_freq <= cw_freq ^ 32'h0000_0f0f;
    @(posedge clk_sys);
    restart_cmd <= 1'b0;
    collect();
    fin1();
    stop("ramp");
    shape_tri <= 1'b1;
    range_center <= 1'b1;
    center_freq <= 32'h0010_0000;
    span_freq <= step_lin * 4 + 32'h0000_0010;
    tick(1);
    gen(center_freq - span_freq / 2, center_freq + span_freq / 2);
    go();
    fin1();
    stop("triangle");
    freq_mode <= FM_SLOPE;
    shape_tri <= 1'b0;
    range_center <= 1'b0;
    spacing_log <= 1'b1;
    retrace <= 1'b1;
    step_log <= 16'h2000;
    step_dwell <= '0;
    stop_freq <= start_freq << 1;
    tick(1);
    gen(start_freq, stop_freq);
    go();
    chk("settle", 1, iv(0) >= SC && iv(0) <= SC + 1);
    fin1();
    retrace <= 1'b0;
    stop("log");
    freq_mode <= FM_STEP;
    spacing_log <= 1'b0;
    run_single <= 1'b0;
    step_dwell <= DWELL_W'(SC + 1);
    stop_freq <= start_freq + step_lin * 3;
    tick(1);
    gen(start_freq, stop_freq);
    ef = {ef, ef};
    ep = {ep, ep};
    go();
    stop("continuous");
    run_single <= 1'b1;
    start_trig <= TRG_MAN;
    point_trig <= TRG_MAN;
    ef = ef[0:3];
    ep = ep[0:3];
    u_syn.clr();
    @(posedge clk_sys);
    sweep_on <= 1'b1;
    point_cmd <= 1'b1;
    @(posedge clk_sys);
    point_cmd <= 1'b0;
    tick(20);
    chk("setpoints before start", 0, u_syn.gf.size());
    start_cmd <= 1'b1;
    @(posedge clk_sys);
    start_cmd <= 1'b0;
    tick(10);
    seen = 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      point_cmd <= 1'b1;
      @(posedge clk_sys);
      point_cmd <= 1'b0;
      #1 seen = seen | (point_delayed === 1'b1);
    end
    collect();
    chk("point_delayed", 1, seen);
    tick(60);
    chk("setpoints manual", 4, u_syn.gf.size());
    stop("manual");
    start_trig <= TRG_EXT;
    point_trig <= TRG_EXT;
    ef = ef[0:2];
    ep = ep[0:2];
    u_syn.clr();
    @(posedge clk_sys);
    sweep_on <= 1'b1;
    start_cmd <= 1'b1;
    @(posedge clk_sys);
    start_cmd <= 1'b0;
    tick(20);
    chk("setpoints before ext", 0, u_syn.gf.size());
    u_syn.fire(3);
    collect();
    stop("external");
    ef = {};
    ep = {};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      tbl_we <= 1'b1;
      tbl_addr <= IDX_W'(i);
      r = nxt();
      tbl_freq <= r;
      ef.push_back(r);
      r = nxt();
      tbl_power <= r[15:0];
      ep.push_back(r[15:0]);
      dw[i] = SC + 2 + 3 * i + (nxt() & 32'h0000_0001);
      tbl_dwell <= DWELL_W'(dw[i]);
    end
    @(posedge clk_sys);
    tbl_we <= 1'b0;
    start_trig <= TRG_AUTO;
    point_trig <= TRG_AUTO;
    freq_mode <= FM_LIST;
    list_stop <= 8'h03;
    global_dwell <= DWELL_W'(SC + 5);
    go();
    chk("list_active", 1, list_active);
    chk("cw_out_active", 0, cw_out_active);
    off = iv(0) - dw[0];
    for (int i = 1; i < 3; i++) chk("entry dwell", off + dw[i], iv(i));
    fin1();
    chk("list_index", list_stop, list_index);
    @(posedge clk_sys);
    sweep_on <= 1'b0;
    list_dwell_global <= 1'b1;
    tick(3);
    go();
    for (int i = 0; i < 3; i++) chk("global dwell", off + SC + 5, iv(i));
    stop("list");
    freq_mode <= FM_CW;
    ef = {cw_freq};
    ep = {cw_power};
    u_syn.clr();
    collect();
    chk("cw_out_active", 1, cw_out_active);
    chk("list_active", 0, list_active);
    chk("strobe faults", 0, u_syn.bad);
    $display("test cw done");
    finish_test();
  end
endmodule // tb_top
